// ===== scr_bank.sv
// System configuration register bank: memory write locks, infrared setup, pin enables.
// Assumes a classic Wishbone master on clk_i and a memory controller on the same clock.
`timescale 1ns/100ps

module scr_bank #(
   parameter bit          KEYED      = 1'b1,
   parameter int unsigned ADC_INPUTS = 10,
   parameter bit          HAS_LCD    = 1'b1
) (
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [scr_pkg::SCR_ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [31:0]                 wb_dat_i,
   output logic      [31:0]                 wb_dat_o,
   output logic                             wb_ack_o,
   input  wire logic                        ir_hw_data_i,
   output scr_pkg::scr_ir_s                 ir_cfg_o,
   output logic                             ir_data_o,
   output logic      [ADC_INPUTS-1:0]       analog_input_pin_on_o,
   output logic                             lcd_supply_pins_on_o,
   output logic                             data_region_write_lock_o,
   output logic                             program_region_write_lock_o,
   input  wire logic                        nvm_wr_req_i,
   input  wire logic                        nvm_wr_data_region_i,
   output logic                             nvm_wr_grant_o
);

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   localparam logic [15:0] PIN_MASK = scr_pkg::scr_pin_mask(ADC_INPUTS, HAS_LCD);

   function automatic logic scr_hit(input logic [scr_pkg::SCR_ADDR_W-1:0] adr,
                                    input logic [5:0] idx);
      return adr == {idx, 2'b00};
   endfunction : scr_hit

   logic        ack_reg;
   logic [31:0] rdata_reg;
   logic        req;
   logic        wr;
   logic        hit_prot;
   logic        hit_ir;
   logic        hit_pin;
   logic        key_ok;
   logic        prot_wr;
   logic [15:0] prot_q;
   logic [15:0] ir_q;
   logic [15:0] pin_q;
   logic [15:0] prot_rd;
   logic [31:0] rdata_next;
   logic        ir_src;
   logic        ir_data_reg;

   // A request is taken once; the registered ack closes it on the next edge.
   assign req      = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr       = req & wb_we_i;
   assign hit_prot = scr_hit(wb_adr_i, scr_pkg::SCR_IDX_PROT);
   assign hit_ir   = scr_hit(wb_adr_i, scr_pkg::SCR_IDX_IR);
   assign hit_pin  = scr_hit(wb_adr_i, scr_pkg::SCR_IDX_PIN);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;

   // ------------------------------------------------------------------
   // Memory protection word
   // ------------------------------------------------------------------
   // The key must arrive in the same word write as the new lock bits, so
   // a lone low-byte write is refused in the keyed variant.
   assign key_ok  = wb_sel_i[1] & wb_sel_i[0] &
                    (wb_dat_i[15:8] == scr_pkg::SCR_KEY_UNLOCK);
   assign prot_wr = wr & hit_prot & (KEYED ? key_ok : wb_sel_i[0]);

   scr_cfg_word #(
      .RESET (scr_pkg::SCR_PROT_RST_BASIC),
      .WMASK (scr_pkg::SCR_PROT_MASK)
   ) u_prot (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .wr_i    (prot_wr),
      .be_i    (wb_sel_i[1:0]),
      .wdata_i (wb_dat_i[15:0]),
      .q_o     (prot_q)
   );

   // The upper byte is never stored; it reads back as a constant.
   assign prot_rd = KEYED ? {scr_pkg::SCR_KEY_READ, prot_q[7:0]} : prot_q;

   assign data_region_write_lock_o    = prot_q[scr_pkg::SCR_DATA_LOCK_BIT];
   assign program_region_write_lock_o = prot_q[scr_pkg::SCR_PROG_LOCK_BIT];

   // Combinational so the memory controller sees the gate in the same cycle.
   assign nvm_wr_grant_o = nvm_wr_req_i &
                           ~(nvm_wr_data_region_i ? data_region_write_lock_o
                                                  : program_region_write_lock_o);

   // ------------------------------------------------------------------
   // Infrared word
   // ------------------------------------------------------------------
   scr_cfg_word #(
      .RESET (scr_pkg::SCR_ZERO16),
      .WMASK (scr_pkg::SCR_IR_MASK)
   ) u_ir (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .wr_i    (wr & hit_ir),
      .be_i    (wb_sel_i[1:0]),
      .wdata_i (wb_dat_i[15:0]),
      .q_o     (ir_q)
   );

   assign ir_cfg_o = scr_pkg::scr_ir_s'(ir_q[scr_pkg::SCR_IR_FIELD_W-1:0]);

   assign ir_src = ir_cfg_o.infrared_source_choice ? ir_cfg_o.infrared_soft_bit
                                                   : ir_hw_data_i;

   // One register stage so the modulator sees a glitch-free data level.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ir_data_reg <= 1'b0;
      end else begin
         ir_data_reg <= ir_cfg_o.infrared_function_on &
                        (ir_src ^ ir_cfg_o.infrared_polarity_invert);
      end
   end

   assign ir_data_o = ir_data_reg;

   // ------------------------------------------------------------------
   // Analog and LCD pin select word
   // ------------------------------------------------------------------
   scr_cfg_word #(
      .RESET (scr_pkg::SCR_ZERO16),
      .WMASK (PIN_MASK)
   ) u_pin (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .wr_i    (wr & hit_pin),
      .be_i    (wb_sel_i[1:0]),
      .wdata_i (wb_dat_i[15:0]),
      .q_o     (pin_q)
   );

   assign analog_input_pin_on_o = pin_q[ADC_INPUTS-1:0];
   assign lcd_supply_pins_on_o  = pin_q[scr_pkg::SCR_LCD_BIT];

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------
   // Reserved bits are absent from the masks, so they read as zero, except pin word bits 15:8 when ADC_INPUTS is 8.
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (hit_prot) begin
         rdata_next[15:0] = prot_rd;
      end else if (hit_ir) begin
         rdata_next[15:0] = ir_q;
      end else if (hit_pin) begin
         rdata_next[15:0] = pin_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (req) begin
         rdata_reg <= wb_we_i ? 32'h0000_0000 : rdata_next;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking

   default disable iff (rst_i);

   chk_ack_single: assert property (
      req |=> wb_ack_o ##1 !wb_ack_o
   ) else $error("ack not a single cycle after request");

   chk_data_lock_reset: assert property (
      @(posedge clk_i) disable iff (1'b0)
      rst_i |=> data_region_write_lock_o
   ) else $error("data lock not set after reset");

   chk_prog_lock_reset: assert property (
      @(posedge clk_i) disable iff (1'b0)
      rst_i |=> program_region_write_lock_o
   ) else $error("program lock not set after reset");

   chk_key_readback: assert property (
      (req && !wb_we_i && hit_prot && KEYED) |=> (wb_dat_o[15:8] == scr_pkg::SCR_KEY_READ)
   ) else $error("key byte did not read back as constant");

   chk_unlock_write: assert property (
      (wr && hit_prot && KEYED && key_ok)
      |=> (program_region_write_lock_o == $past(wb_dat_i[0]))
          && (data_region_write_lock_o == $past(wb_dat_i[1]))
   ) else $error("keyed write did not update lock bits");

   chk_split_refused: assert property (
      (wr && hit_prot && KEYED && (wb_sel_i[1:0] != 2'b11))
      |=> $stable(prot_q)
   ) else $error("byte write changed lock bits");

   chk_bad_key_hold: assert property (
      (wr && hit_prot && KEYED && (wb_dat_i[15:8] != scr_pkg::SCR_KEY_UNLOCK))
      |=> $stable(data_region_write_lock_o) && $stable(program_region_write_lock_o)
   ) else $error("wrong key changed lock bits");

   chk_rsvd_zero: assert property (
      (req && !wb_we_i && hit_ir) |=> (wb_dat_o[31:5] == 27'h000_0000)
   ) else $error("reserved infrared bits not zero");

   chk_ir_off: assert property (
      !ir_cfg_o.infrared_function_on |=> !ir_data_o
   ) else $error("infrared data active while disabled");

   chk_ir_soft_path: assert property (
      (ir_cfg_o.infrared_function_on && ir_cfg_o.infrared_source_choice)
      |=> ir_data_o == ($past(ir_cfg_o.infrared_soft_bit)
                        ^ $past(ir_cfg_o.infrared_polarity_invert))
   ) else $error("soft infrared data path wrong");

   chk_ir_hw_invert: assert property (
      (ir_cfg_o.infrared_function_on && !ir_cfg_o.infrared_source_choice)
      |=> ir_data_o == ($past(ir_hw_data_i) ^ $past(ir_cfg_o.infrared_polarity_invert))
   ) else $error("peripheral infrared data path wrong");

   chk_ir_fields: assert property (
      (wr && hit_ir && wb_sel_i[0])
      |=> ir_cfg_o == scr_pkg::scr_ir_s'($past(wb_dat_i[4:0]))
   ) else $error("infrared fields not written");

   chk_ir_reset: assert property (
      @(posedge clk_i) disable iff (1'b0)
      rst_i |=> (ir_q == scr_pkg::SCR_ZERO16) && !ir_data_o
   ) else $error("infrared word not cleared by reset");

   chk_pin_write: assert property (
      (wr && hit_pin && wb_sel_i[0])
      |=> analog_input_pin_on_o[0] == $past(wb_dat_i[0])
   ) else $error("analog pin enable not written");

   chk_lcd_write: assert property (
      (wr && hit_pin && wb_sel_i[1] && HAS_LCD)
      |=> lcd_supply_pins_on_o == $past(wb_dat_i[scr_pkg::SCR_LCD_BIT])
   ) else $error("lcd supply enable not written");

   chk_keyed_reset: assert property (
      @(posedge clk_i) disable iff (1'b0)
      (rst_i && KEYED) |=> (prot_rd == scr_pkg::SCR_PROT_RST_KEYED)
                           && (pin_q == scr_pkg::SCR_ZERO16)
   ) else $error("keyed reset value wrong");

   chk_basic_reset: assert property (
      @(posedge clk_i) disable iff (1'b0)
      (rst_i && !KEYED) |=> (prot_rd == scr_pkg::SCR_PROT_RST_BASIC)
   ) else $error("basic reset value wrong");

   chk_grant_gate: assert property (
      (nvm_wr_req_i && nvm_wr_data_region_i && data_region_write_lock_o) |-> !nvm_wr_grant_o
   ) else $error("write granted into locked data region");

   chk_grant_prog: assert property (
      (nvm_wr_req_i && !nvm_wr_data_region_i && program_region_write_lock_o)
      |-> !nvm_wr_grant_o
   ) else $error("write granted into locked program region");

   chk_grant_open: assert property (
      (nvm_wr_req_i && !nvm_wr_data_region_i && !program_region_write_lock_o)
      |-> nvm_wr_grant_o
   ) else $error("write refused into open program region");

   // ------------------------------------------------------------------
   // Read path, hold and ack checks
   // ------------------------------------------------------------------
   // A word that is not written must not move, so a stray strobe or a refused
   // key can never change a lock or a pin enable behind software's back.
   chk_unmapped_zero: assert property (
      (req && !hit_prot && !hit_ir && !hit_pin) |=> (wb_dat_o == 32'h0000_0000)
   ) else $error("unmapped address did not read zero");

   chk_pin_rsvd: assert property (
      (req && !wb_we_i && hit_pin)
      |=> ((wb_dat_o[15:0] & ~PIN_MASK) == scr_pkg::SCR_ZERO16)
   ) else $error("reserved pin select bits not zero");

   chk_lock_readback: assert property (
      (req && !wb_we_i && hit_prot)
      |=> (wb_dat_o[scr_pkg::SCR_DATA_LOCK_BIT] == data_region_write_lock_o)
          && (wb_dat_o[scr_pkg::SCR_PROG_LOCK_BIT] == program_region_write_lock_o)
   ) else $error("lock bits read back wrong");

   chk_pin_readback: assert property (
      (req && !wb_we_i && hit_pin) |=> (wb_dat_o[15:0] == pin_q)
   ) else $error("pin select word read back wrong");

   chk_dat_hi_zero: assert property (
      wb_dat_o[31:16] == 16'h0000
   ) else $error("upper read data half not zero");

   chk_prot_hold: assert property (
      !prot_wr |=> $stable(prot_q)
   ) else $error("lock bits moved without accepted write");

   chk_ir_hold: assert property (
      !(wr && hit_ir) |=> $stable(ir_q)
   ) else $error("infrared word moved without write");

   chk_pin_hold: assert property (
      !(wr && hit_pin) |=> $stable(pin_q)
   ) else $error("pin select word moved without write");

   chk_ack_after_req: assert property (
      wb_ack_o |-> $past(req)
   ) else $error("ack without a taken request");

   chk_ack_drop: assert property (
      wb_ack_o |=> !wb_ack_o
   ) else $error("ack held for more than one cycle");

   cov_unlock: cover property (wr && hit_prot && key_ok ##1 !program_region_write_lock_o);
   cov_data_unlock: cover property (prot_wr ##1 !data_region_write_lock_o);
   cov_ir_soft: cover property (ir_cfg_o.infrared_source_choice ##1 ir_data_o);
   cov_unmapped: cover property (req && !hit_prot && !hit_ir && !hit_pin ##1 wb_ack_o);
   cov_grant: cover property (nvm_wr_grant_o && nvm_wr_data_region_i);

endmodule : scr_bank

// ===== scr_pkg.sv
// Constants, field layout and carrier types of the system configuration register bank.
// Assumes a classic Wishbone slave with 32-bit data, one register per aligned word.

package scr_pkg;

   // ------------------------------------------------------------------
   // Bus geometry and register placement
   // ------------------------------------------------------------------
   localparam int unsigned SCR_ADDR_W  = 8;
   localparam int unsigned SCR_REG_W   = 16;
   // Register indices; byte address is four times the index.
   localparam logic [5:0]  SCR_IDX_PROT = 6'h00;
   localparam logic [5:0]  SCR_IDX_IR   = 6'h02;
   localparam logic [5:0]  SCR_IDX_PIN  = 6'h04;

   // ------------------------------------------------------------------
   // Memory protection register
   // ------------------------------------------------------------------
   localparam int unsigned SCR_PROG_LOCK_BIT   = 0;
   localparam int unsigned SCR_DATA_LOCK_BIT   = 1;
   localparam logic [7:0]  SCR_KEY_READ        = 8'h96;
   localparam logic [7:0]  SCR_KEY_UNLOCK      = 8'hA5;
   localparam logic [15:0] SCR_PROT_MASK       = 16'h0003;
   localparam logic [15:0] SCR_PROT_RST_BASIC  = 16'h0003;
   localparam logic [15:0] SCR_PROT_RST_KEYED  = 16'h9603;

   // ------------------------------------------------------------------
   // Infrared and pin select registers
   // ------------------------------------------------------------------
   localparam int unsigned SCR_IR_FIELD_W      = 5;
   localparam logic [15:0] SCR_IR_MASK         = 16'h001F;
   localparam int unsigned SCR_LCD_BIT         = 12;
   localparam int unsigned SCR_ADC_NARROW      = 8;
   localparam logic [15:0] SCR_NARROW_SPARE    = 16'hFF00;
   localparam logic [15:0] SCR_ZERO16          = 16'h0000;

   // Field order matches bits 4 down to 0 of the infrared register.
   typedef struct packed {
      logic infrared_soft_bit;
      logic infrared_source_choice;
      logic infrared_modulation_kind;
      logic infrared_polarity_invert;
      logic infrared_function_on;
   } scr_ir_s;

   function automatic logic [15:0] scr_pin_mask(input int unsigned n, input bit lcd);
      logic [15:0] m;
      m = SCR_ZERO16;
      for (int i = 0; i < SCR_REG_W; i++) begin
         if (i < n) begin
            m[i] = 1'b1;
         end
      end
      if (lcd) begin
         m[SCR_LCD_BIT] = 1'b1;
      end
      if (n == SCR_ADC_NARROW) begin
         m = m | SCR_NARROW_SPARE;
      end
      return m;
   endfunction : scr_pin_mask

endpackage : scr_pkg

// ===== scr_cfg_word.sv
// One 16-bit configuration word with per-byte write enables and a mask of writable bits.
// Assumes the caller has already decoded address and access rights.
`timescale 1ns/100ps

module scr_cfg_word #(
   parameter logic [15:0] RESET = 16'h0000,
   parameter logic [15:0] WMASK = 16'hFFFF
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wr_i,
   input  wire logic [1:0]  be_i,
   input  wire logic [15:0] wdata_i,
   output logic      [15:0] q_o
);

   logic [15:0] lane_mask;

   // Bits outside the mask never leave their reset value.
   assign lane_mask = WMASK & {{8{be_i[1]}}, {8{be_i[0]}}};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_o <= RESET & WMASK;
      end else if (wr_i) begin
         q_o <= (q_o & ~lane_mask) | (wdata_i & lane_mask);
      end
   end

endmodule : scr_cfg_word

// ===== scr_bank_tb.sv
// Self-checking testbench for the system configuration register bank.
// Assumes the default build: keyed protection, ten analog inputs, LCD supply enable.
`timescale 1ns/100ps

module scr_bank_tb;

   // ---------------------------------------------------------------
   // Stimulus signals and design instance
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [15:0] wdat;
      logic        wr;
      logic [15:0] exp;
   } scr_tb_row_s;

   logic             clk_i                = 1'b0;
   logic             rst_i                = 1'b1;
   logic             wb_cyc_i             = 1'b0;
   logic             wb_stb_i             = 1'b0;
   logic             wb_we_i              = 1'b0;
   logic [7:0]       wb_adr_i             = 8'h00;
   logic [3:0]       wb_sel_i             = 4'h0;
   logic [31:0]      wb_dat_i             = 32'h0000_0000;
   logic [31:0]      wb_dat_o;
   logic             wb_ack_o;
   logic             ir_hw_data_i         = 1'b0;
   scr_pkg::scr_ir_s ir_cfg_o;
   logic             ir_data_o;
   logic [9:0]       analog_input_pin_on_o;
   logic             lcd_supply_pins_on_o;
   logic             data_region_write_lock_o;
   logic             program_region_write_lock_o;
   logic             nvm_wr_req_i         = 1'b0;
   logic             nvm_wr_data_region_i = 1'b0;
   logic             nvm_wr_grant_o;
   logic [31:0]      rd;
   int               errors               = 0;
   int               comparisons          = 0;

   // Rows run in order; each one builds on the state the previous rows left.
   scr_tb_row_s rows [0:9] = '{
      '{8'h00, 4'h0, 16'h0000, 1'b0, 16'h9603},
      '{8'h08, 4'h0, 16'h0000, 1'b0, 16'h0000},
      '{8'h10, 4'h0, 16'h0000, 1'b0, 16'h0000},
      '{8'h00, 4'h3, 16'h1200, 1'b1, 16'h9603},
      '{8'h00, 4'h1, 16'h0000, 1'b1, 16'h9603},
      '{8'h00, 4'h3, 16'hA500, 1'b1, 16'h9600},
      '{8'h08, 4'h3, 16'hFFFF, 1'b1, 16'h001F},
      '{8'h10, 4'h3, 16'hFFFF, 1'b1, 16'h13FF},
      '{8'h0C, 4'h3, 16'hFFFF, 1'b1, 16'h0000},
      '{8'h00, 4'h3, 16'hA502, 1'b1, 16'h9602}
   };

   // Each entry: infrared control word, hardware data level, expected output.
   logic [17:0] ir_rows [0:5] = '{
      {16'h0001, 1'b1, 1'b1},
      {16'h0001, 1'b0, 1'b0},
      {16'h0003, 1'b0, 1'b1},
      {16'h0019, 1'b0, 1'b1},
      {16'h0009, 1'b1, 1'b0},
      {16'h0018, 1'b1, 1'b0}
   };

   scr_bank u_scr_bank (
      .clk_i                       (clk_i),
      .rst_i                       (rst_i),
      .wb_cyc_i                    (wb_cyc_i),
      .wb_stb_i                    (wb_stb_i),
      .wb_we_i                     (wb_we_i),
      .wb_adr_i                    (wb_adr_i),
      .wb_sel_i                    (wb_sel_i),
      .wb_dat_i                    (wb_dat_i),
      .wb_dat_o                    (wb_dat_o),
      .wb_ack_o                    (wb_ack_o),
      .ir_hw_data_i                (ir_hw_data_i),
      .ir_cfg_o                    (ir_cfg_o),
      .ir_data_o                   (ir_data_o),
      .analog_input_pin_on_o       (analog_input_pin_on_o),
      .lcd_supply_pins_on_o        (lcd_supply_pins_on_o),
      .data_region_write_lock_o    (data_region_write_lock_o),
      .program_region_write_lock_o (program_region_write_lock_o),
      .nvm_wr_req_i                (nvm_wr_req_i),
      .nvm_wr_data_region_i        (nvm_wr_data_region_i),
      .nvm_wr_grant_o              (nvm_wr_grant_o)
   );

   always #5 clk_i = ~clk_i;

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Ack and read data are taken at the rising edge at which ack is seen high, and the
   // request is released by non-blocking assignment at that same edge, never earlier.
   task automatic wb_xfer(input logic wr, input logic [7:0] adr, input logic [3:0] sel,
                          input logic [31:0] dat, output logic [31:0] rdat);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= wr;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 16) begin
         @(posedge clk_i);
         n++;
      end
      check("bus ack", 32'h0000_0001, {31'h0, wb_ack_o});
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb_xfer

   task automatic run_rows(input int first, input int last);
      for (int i = first; i <= last; i++) begin
         if (rows[i].wr) begin
            wb_xfer(1'b1, rows[i].adr, rows[i].sel, {16'h0000, rows[i].wdat}, rd);
         end
         wb_xfer(1'b0, rows[i].adr, 4'hF, 32'h0000_0000, rd);
         check("read data", {16'h0000, rows[i].exp}, rd);
         @(negedge clk_i);
         case (rows[i].adr)
            8'h00: check("write locks", {30'h0, rows[i].exp[1:0]},
                         {30'h0, data_region_write_lock_o, program_region_write_lock_o});
            8'h08: check("ir config", {27'h0, rows[i].exp[4:0]}, {27'h0, ir_cfg_o});
            8'h10: check("pin enables", {19'h0, rows[i].exp[12], 2'b00, rows[i].exp[9:0]},
                         {19'h0, lcd_supply_pins_on_o, 2'b00, analog_input_pin_on_o});
            default: ;
         endcase
      end
   endtask : run_rows

   task automatic grant_check(input logic req, input logic data_rgn, input logic exp);
      @(posedge clk_i);
      nvm_wr_req_i         <= req;
      nvm_wr_data_region_i <= data_rgn;
      @(negedge clk_i);
      check("nvm grant", {31'h0, exp}, {31'h0, nvm_wr_grant_o});
   endtask : grant_check

   task automatic print_verdict;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      grant_check(1'b1, 1'b1, 1'b0);
      run_rows(0, 5);
      // Both regions are open here, so a data region write must pass.
      grant_check(1'b1, 1'b1, 1'b1);
      run_rows(6, 9);
      // Data region was locked again by the last row, program region stays unlocked.
      grant_check(1'b1, 1'b1, 1'b0);
      grant_check(1'b1, 1'b0, 1'b1);
      grant_check(1'b0, 1'b0, 1'b0);
      for (int i = 0; i < 6; i++) begin
         wb_xfer(1'b1, 8'h08, 4'h3, {16'h0000, ir_rows[i][17:2]}, rd);
         @(posedge clk_i);
         ir_hw_data_i <= ir_rows[i][1];
         repeat (2) @(posedge clk_i);
         @(negedge clk_i);
         check("ir data", {31'h0, ir_rows[i][0]}, {31'h0, ir_data_o});
      end
      // A second reset in mid-run must restore every power-up value.
      wb_xfer(1'b1, 8'h10, 4'h3, 32'h0000_1001, rd);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      run_rows(0, 2);
      grant_check(1'b1, 1'b0, 1'b0);
      print_verdict();
   end

   initial begin
      repeat (3000) @(posedge clk_i);
      errors++;
      print_verdict();
   end

endmodule : scr_bank_tb
